//--- hw/bil_loader.sv
// Boot image loader: reset hold, reset sequence, image fetch, copy, CRC check, PLL setup.
// Assumes all inputs synchronous to mclk_i; OTP returns a word the cycle after a read.
`include "bil_defines.svh"

// Function
// - Hold in reset while reset pin low
// - Pull-downs on all GPIO during reset
// - Internal reset sequence, then boot
// - Security bit 5 selects OTP, else flash
// - Image: size words, program, check word
// - Skip value accepts without CRC
// - Size and check assembled LSB first
// - Load at RAM base, start there
// - CRC over size and program bytes
// - Reflected CRC-32, preset ones, inverted
// - Boot PLL: divider 1, feedback 63, ref 0
// - Tile clock ratio from three dividers
// - PLL values writable by software
// - Flash fetched over tile 0 QSPI pins
// - Secure boot starts at OTP address 0
module bil_loader
  import bil_pkg::*;
#(
  parameter int RAM_AW = 16,
  parameter int OTP_AW = 11
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic dev_rst_n_i,
  input wire logic [31:0] security_i,
  input wire logic [31:0] otp_data_i,
  input wire logic [3:0] qspi_io_i,
  input wire logic pll_wr_i,
  input wire logic [2:0] pll_od_i,
  input wire logic [11:0] pll_f_i,
  input wire logic [5:0] pll_r_i,
  output logic gpio_pd_en_o,
  output logic boot_otp_o,
  output logic boot_done_o,
  output logic boot_err_o,
  output logic core_run_o,
  output logic [RAM_AW-1:0] start_addr_o,
  output logic otp_rd_o,
  output logic [OTP_AW-1:0] otp_addr_o,
  output logic ram_we_o,
  output logic [RAM_AW-1:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  output logic qspi_sclk_o,
  output logic qspi_cs_n_o,
  output logic [3:0] qspi_io_o,
  output logic [3:0] qspi_io_oe_o,
  output logic [2:0] pll_output_divider_o,
  output logic [11:0] pll_f_o,
  output logic [5:0] pll_r_o,
  output logic [12:0] pll_num_o,
  output logic [11:0] pll_den_o
);
  localparam int SEQ_CYC = `BIL_RST_SEQ_CYC;

  bil_state_type state_r;
  bil_state_type state_nxt;

  bil_byte_if bus ();

  logic [7:0] seq_cnt_r;
  logic otp_mode_r;
  logic go_r;
  logic [1:0] lane_r;
  logic [31:0] asm_r;
  logic [31:0] asm_nxt;
  logic [33:0] left_r;
  logic [RAM_AW-1:0] wptr_r;
  logic [31:0] crc_w;
  logic crc_en;
  logic crc_init;
  logic pass_w;

  logic otp_pend_r;
  logic otp_have_r;
  logic [1:0] otp_lane_r;
  logic [31:0] otp_word_r;

  logic byte_vld;
  logic [7:0] byte_dat;

  // One byte stream whichever source is active
  always_comb begin
    if (otp_mode_r) begin
      byte_vld = otp_have_r;
      byte_dat = otp_word_r[otp_lane_r*8 +: 8];
    end else begin
      byte_vld = bus.valid;
      byte_dat = bus.data;
    end
  end

  assign asm_nxt = {byte_dat, asm_r[31:8]};
  assign pass_w = (asm_nxt == `BIL_SKIP_CRC) || (asm_nxt == crc_w);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BIL_HOLD: begin
        if (dev_rst_n_i) begin
          state_nxt = BIL_SEQ;
        end
      end
      BIL_SEQ: begin
        if (seq_cnt_r == 8'(SEQ_CYC - 1)) begin
          state_nxt = BIL_SIZE;
        end
      end
      BIL_SIZE: begin
        if (byte_vld && lane_r == `BIL_WORD_LAST) begin
          state_nxt = (asm_nxt == 32'h0000_0000) ? BIL_CHECK : BIL_PROG;
        end
      end
      BIL_PROG: begin
        if (byte_vld && left_r == 34'h0_0000_0001) begin
          state_nxt = BIL_CHECK;
        end
      end
      BIL_CHECK: begin
        if (byte_vld && lane_r == `BIL_WORD_LAST) begin
          state_nxt = pass_w ? BIL_RUN : BIL_ERR;
        end
      end
      BIL_RUN: begin
        state_nxt = BIL_RUN;
      end
      BIL_ERR: begin
        state_nxt = BIL_ERR;
      end
      default: begin
        state_nxt = BIL_HOLD;
      end
    endcase
    if (!dev_rst_n_i) begin
      state_nxt = BIL_HOLD;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= BIL_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reset sequence timer; minimum figure keeps boot inside the window at any clock whose cycle count fits the 8-bit counter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_cnt_r <= 8'h00;
    end else if (state_r == BIL_SEQ) begin
      seq_cnt_r <= seq_cnt_r + 8'h01;
    end else begin
      seq_cnt_r <= 8'h00;
    end
  end

  // Boot source caught once, as the sequence ends, so a later change has no effect
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      otp_mode_r <= 1'b0;
    end else if (state_r == BIL_SEQ && state_nxt == BIL_SIZE) begin
      otp_mode_r <= security_i[`BIL_SEC_BOOT_BIT];
    end
  end

  // Source bit read directly as the sequence ends; the mode flop still holds the last boot's source then
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      go_r <= 1'b0;
    end else begin
      go_r <= !((state_r == BIL_SEQ) ? security_i[`BIL_SEC_BOOT_BIT] : otp_mode_r)
              && (state_nxt == BIL_SIZE || state_nxt == BIL_PROG || state_nxt == BIL_CHECK);
    end
  end

  assign bus.go = go_r;

  // Field assembly
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lane_r <= 2'h0;
      asm_r <= 32'h0000_0000;
    end else if (state_r == BIL_SEQ) begin
      lane_r <= 2'h0;
    end else if (byte_vld && (state_r == BIL_SIZE || state_r == BIL_CHECK)) begin
      lane_r <= lane_r + 2'h1;
      asm_r <= asm_nxt;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      left_r <= 34'h0_0000_0000;
    end else if (state_r == BIL_SIZE && byte_vld && lane_r == `BIL_WORD_LAST) begin
      left_r <= {asm_nxt, 2'b00};
    end else if (state_r == BIL_PROG && byte_vld) begin
      left_r <= left_r - 34'h0_0000_0001;
    end
  end

  // Program copy into RAM
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_r <= RAM_AW'(`BIL_RAM_BASE);
      ram_we_o <= 1'b0;
      ram_addr_o <= '0;
      ram_wdata_o <= 8'h00;
    end else begin
      ram_we_o <= 1'b0;
      if (state_r == BIL_SEQ) begin
        wptr_r <= RAM_AW'(`BIL_RAM_BASE);
      end else if (state_r == BIL_PROG && byte_vld) begin
        ram_we_o <= 1'b1;
        ram_addr_o <= wptr_r;
        ram_wdata_o <= byte_dat;
        wptr_r <= wptr_r + RAM_AW'(1);
      end
    end
  end

  assign crc_init = (state_r == BIL_SEQ);
  assign crc_en = byte_vld && (state_r == BIL_SIZE || state_r == BIL_PROG);

  bil_crc32 u_crc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .init_i(crc_init),
    .en_i(crc_en),
    .data_i(byte_dat),
    .crc_o(crc_w)
  );

  bil_qspi_rd u_qspi (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .bus(bus),
    .io_i(qspi_io_i),
    .sclk_o(qspi_sclk_o),
    .cs_n_o(qspi_cs_n_o),
    .io_o(qspi_io_o),
    .io_oe_o(qspi_io_oe_o)
  );

  // OTP word fetch; bytes leave least significant first, one word at a time
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      otp_rd_o <= 1'b0;
      otp_addr_o <= OTP_AW'(`BIL_OTP_BASE);
      otp_pend_r <= 1'b0;
      otp_have_r <= 1'b0;
      otp_lane_r <= 2'h0;
      otp_word_r <= 32'h0000_0000;
    end else if (!otp_mode_r || state_r == BIL_HOLD || state_r == BIL_SEQ
                 || state_r == BIL_RUN || state_r == BIL_ERR) begin
      otp_rd_o <= 1'b0;
      otp_addr_o <= OTP_AW'(`BIL_OTP_BASE);
      otp_pend_r <= 1'b0;
      otp_have_r <= 1'b0;
      otp_lane_r <= 2'h0;
    end else if (otp_rd_o) begin
      otp_rd_o <= 1'b0;
      otp_pend_r <= 1'b1;
    end else if (otp_pend_r) begin
      otp_pend_r <= 1'b0;
      otp_word_r <= otp_data_i;
      otp_have_r <= 1'b1;
      otp_addr_o <= otp_addr_o + OTP_AW'(1);
    end else if (otp_have_r) begin
      otp_lane_r <= otp_lane_r + 2'h1;
      if (otp_lane_r == `BIL_WORD_LAST) begin
        otp_have_r <= 1'b0;
      end
    end else begin
      otp_rd_o <= 1'b1;
    end
  end

  // Status and pin control
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gpio_pd_en_o <= 1'b1;
      boot_otp_o <= 1'b0;
      boot_done_o <= 1'b0;
      boot_err_o <= 1'b0;
      core_run_o <= 1'b0;
      start_addr_o <= RAM_AW'(`BIL_RAM_BASE);
    end else begin
      gpio_pd_en_o <= (state_nxt == BIL_HOLD);
      boot_otp_o <= otp_mode_r;
      boot_done_o <= (state_nxt == BIL_RUN);
      boot_err_o <= (state_nxt == BIL_ERR);
      core_run_o <= (state_nxt == BIL_RUN);
      start_addr_o <= RAM_AW'(`BIL_RAM_BASE);
    end
  end

  // PLL dividers; range checks are left to software, the hardware stores as written
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_output_divider_o <= `BIL_PLL_OD_BOOT;
      pll_f_o <= `BIL_PLL_F_BOOT;
      pll_r_o <= `BIL_PLL_R_BOOT;
    end else if (pll_wr_i) begin
      pll_output_divider_o <= pll_od_i;
      pll_f_o <= pll_f_i;
      pll_r_o <= pll_r_i;
    end
  end

  // Ratio as numerator over denominator; lags the divider values by one cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_num_o <= 13'(int'(`BIL_PLL_F_BOOT) + 1);
      pll_den_o <= 12'(2 * (int'(`BIL_PLL_R_BOOT) + 1) * (int'(`BIL_PLL_OD_BOOT) + 1));
    end else begin
      pll_num_o <= 13'(int'(pll_f_o) + 1);
      pll_den_o <= 12'(2 * (int'(pll_r_o) + 1) * (int'(pll_output_divider_o) + 1));
    end
  end
endmodule

//--- hw/bil_defines.svh
// Constants of the boot image loader: offsets, field values, timing figures.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BIL_DEFINES_SVH
`define BIL_DEFINES_SVH

`define BIL_SEC_BOOT_BIT 5
`define BIL_SKIP_CRC 32'h0D15_AB1E
`define BIL_CRC_POLY 32'hEDB8_8320
`define BIL_CRC_INIT 32'hFFFF_FFFF
`define BIL_PLL_OD_BOOT 3'h1
`define BIL_PLL_F_BOOT 12'h03F
`define BIL_PLL_R_BOOT 6'h00
`define BIL_CLK_NS 100
`define BIL_RST_SEQ_NS 15000
`define BIL_RST_SEQ_CYC ((`BIL_RST_SEQ_NS + `BIL_CLK_NS - 1) / `BIL_CLK_NS)
`define BIL_RAM_BASE 16'h0000
`define BIL_OTP_BASE 11'h000
`define BIL_QSPI_CMDW 32'h6B00_0000
`define BIL_QSPI_HDR_LAST 6'h1F
`define BIL_QSPI_DUMMY_LAST 6'h07
`define BIL_WORD_LAST 2'h3

`endif

//--- hw/bil_pkg.sv
// Types shared by the boot image loader modules.
// Assumes nothing beyond a SystemVerilog compiler.
package bil_pkg;
  typedef enum {
    BIL_HOLD,
    BIL_SEQ,
    BIL_SIZE,
    BIL_PROG,
    BIL_CHECK,
    BIL_RUN,
    BIL_ERR
  } bil_state_type;

  typedef enum {
    BIL_Q_IDLE,
    BIL_Q_HDR,
    BIL_Q_DUMMY,
    BIL_Q_DATA
  } bil_qspi_state_type;
endpackage

//--- hw/bil_byte_if.sv
// Byte stream from the flash reader to the loader.
// Assumes one clock shared by both ends.
interface bil_byte_if;
  logic go;
  logic valid;
  logic [7:0] data;
  modport ldr (output go, input valid, input data);
  modport src (input go, output valid, output data);
endinterface

//--- hw/bil_crc32.sv
// Byte-serial reflected CRC-32 with inverted residue.
// Assumes init and enable never coincide.
`include "bil_defines.svh"
module bil_crc32 (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic init_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  output logic [31:0] crc_o
);
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  always_comb begin
    crc_nxt = crc_r ^ {24'h00_0000, data_i};
    for (int i = 0; i < 8; i++) begin
      crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ `BIL_CRC_POLY) : (crc_nxt >> 1);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_r <= `BIL_CRC_INIT;
    end else if (init_i) begin
      crc_r <= `BIL_CRC_INIT;
    end else if (en_i) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_o = ~crc_r;
endmodule

//--- hw/bil_qspi_rd.sv
// Quad-output flash reader: sends read header from address zero, then streams bytes.
// Assumes the flash samples on rising clock and drives on falling; clock is mclk/2.
`include "bil_defines.svh"
module bil_qspi_rd
  import bil_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  bil_byte_if.src bus,
  input wire logic [3:0] io_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  bil_qspi_state_type st_r;
  logic [31:0] sh_r;
  logic [5:0] cnt_r;
  logic [7:0] byte_r;
  logic nib_r;
  logic vld_r;
  logic [31:0] hdr_w;

  assign hdr_w = `BIL_QSPI_CMDW;
  assign bus.valid = vld_r;
  assign bus.data = byte_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= BIL_Q_IDLE;
      sh_r <= 32'h0000_0000;
      cnt_r <= 6'h00;
      byte_r <= 8'h00;
      nib_r <= 1'b0;
      vld_r <= 1'b0;
      sclk_o <= 1'b0;
      cs_n_o <= 1'b1;
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end else if (!bus.go) begin
      st_r <= BIL_Q_IDLE;
      vld_r <= 1'b0;
      sclk_o <= 1'b0;
      cs_n_o <= 1'b1;
      io_oe_o <= 4'h0;
    end else begin
      vld_r <= 1'b0;
      case (st_r)
        BIL_Q_IDLE: begin
          cs_n_o <= 1'b0;
          io_oe_o <= 4'h1;
          io_o <= {3'b000, hdr_w[31]};
          sh_r <= {hdr_w[30:0], 1'b0};
          cnt_r <= 6'h00;
          nib_r <= 1'b0;
          st_r <= BIL_Q_HDR;
        end
        BIL_Q_HDR: begin
          sclk_o <= !sclk_o;
          if (sclk_o) begin
            cnt_r <= cnt_r + 6'h01;
            io_o <= {3'b000, sh_r[31]};
            sh_r <= {sh_r[30:0], 1'b0};
            if (cnt_r == `BIL_QSPI_HDR_LAST) begin
              io_oe_o <= 4'h0;
              cnt_r <= 6'h00;
              st_r <= BIL_Q_DUMMY;
            end
          end
        end
        BIL_Q_DUMMY: begin
          sclk_o <= !sclk_o;
          if (sclk_o) begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == `BIL_QSPI_DUMMY_LAST) begin
              st_r <= BIL_Q_DATA;
            end
          end
        end
        BIL_Q_DATA: begin
          sclk_o <= !sclk_o;
          if (sclk_o) begin
            byte_r <= {byte_r[3:0], io_i};
            nib_r <= !nib_r;
            vld_r <= nib_r;
          end
        end
        default: begin
          st_r <= BIL_Q_IDLE;
        end
      endcase
    end
  end
endmodule

//--- tb/bil_loader_properties.sv
// Port checker of the boot loader.
// Bound to bil_loader from the bench top file; one clock domain.
module bil_loader_chk #(
  parameter int RAM_AW = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic dev_rst_n_i,
  input wire logic pll_wr_i,
  input wire logic [2:0] pll_od_i,
  input wire logic [11:0] pll_f_i,
  input wire logic [5:0] pll_r_i,
  input wire logic gpio_pd_en_o,
  input wire logic boot_otp_o,
  input wire logic boot_done_o,
  input wire logic boot_err_o,
  input wire logic core_run_o,
  input wire logic otp_rd_o,
  input wire logic ram_we_o,
  input wire logic [RAM_AW-1:0] ram_addr_o,
  input wire logic qspi_cs_n_o,
  input wire logic [2:0] pll_output_divider_o,
  input wire logic [11:0] pll_f_o,
  input wire logic [5:0] pll_r_o,
  input wire logic [12:0] pll_num_o,
  input wire logic [11:0] pll_den_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_seen_r;
  logic we_seen_r;
  logic [RAM_AW-1:0] last_r;
  logic [8:0] seq_cnt_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) wr_seen_r <= 1'b0;
    else if (pll_wr_i) wr_seen_r <= 1'b1;
  end
  // Saturates so a long run never wraps back under the minimum
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) seq_cnt_r <= 9'h000;
    else if (gpio_pd_en_o) seq_cnt_r <= 9'h000;
    else if (seq_cnt_r != 9'h1FF) seq_cnt_r <= seq_cnt_r + 9'h001;
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) we_seen_r <= 1'b0;
    else if (gpio_pd_en_o) we_seen_r <= 1'b0;
    else if (ram_we_o) we_seen_r <= 1'b1;
  end
  always_ff @(posedge mclk_i) begin
    if (ram_we_o) last_r <= ram_addr_o;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_hold_pd: assert property (!dev_rst_n_i |=> gpio_pd_en_o && !core_run_o)
    else $error("hold state wrong");
  chk_seq_len: assert property ((!qspi_cs_n_o || otp_rd_o) |-> seq_cnt_r >= 9'h094)
    else $error("fetch too early");
  chk_src_sel: assert property (otp_rd_o |-> boot_otp_o && qspi_cs_n_o)
    else $error("otp read while flash boot");
  chk_flash_src: assert property (!qspi_cs_n_o |-> !boot_otp_o)
    else $error("flash used in otp boot");
  chk_ram_base: assert property (ram_we_o && !we_seen_r |-> ram_addr_o == '0)
    else $error("first write not at base");
  chk_ram_step: assert property (ram_we_o && we_seen_r |-> ram_addr_o == last_r + 1'b1)
    else $error("write address skipped");
  chk_err_stop: assert property (boot_err_o |-> !core_run_o && !boot_done_o)
    else $error("run with crc error");
  chk_pll_load: assert property (pll_wr_i |=> pll_output_divider_o == $past(pll_od_i) &&
    pll_f_o == $past(pll_f_i) && pll_r_o == $past(pll_r_i))
    else $error("pll write lost");
  chk_pll_boot: assert property (!wr_seen_r |-> {pll_output_divider_o, pll_f_o, pll_r_o} == 21'h04_0FC0)
    else $error("boot pll values wrong");
  chk_pll_ratio: assert property (pll_wr_i ##1 !pll_wr_i |=> pll_num_o == pll_f_o + 13'h0001 &&
    pll_den_o == 12'(2 * (pll_r_o + 1) * (pll_output_divider_o + 1)))
    else $error("pll ratio wrong");
endmodule

//--- tb/bil_flash_mdl.sv
// Boot flash model: quad output read, data after 32 header and 8 dummy clocks.
// Assumes the loader samples data on the edge where its serial clock falls.
module bil_flash_mdl (
  input wire logic clk_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic io0_i,
  output logic [3:0] io_o,
  output logic [31:0] cmd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  int fall_n = 0;
  initial io_o = 4'h5;
  always @(posedge clk_i) begin
    if (cs_n_i) begin
      io_o <= ~io_o; // Deselected lines never hold a stale value
      fall_n <= 0;
    end else if (sclk_i) begin
      if (fall_n < 32) cmd_o <= {cmd_o[30:0], io0_i};
      if (fall_n >= 39) io_o <= fall_n[0] ? mem[(fall_n - 39) / 2][7:4] : mem[(fall_n - 39) / 2][3:0];
      fall_n <= fall_n + 1;
    end
  end
endmodule

//--- tb/bil_loader_tb.sv
// Bench of the boot loader: flash and OTP boots, abort, PLL writes.
// Assumes the flash model and checker files are compiled first.
module bil_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, rst_i, dev_rst_n_i, pll_wr_i, gpio_pd_en_o, boot_otp_o, boot_done_o;
  logic boot_err_o, core_run_o, otp_rd_o, ram_we_o, qspi_sclk_o, qspi_cs_n_o;
  logic [31:0] security_i, otp_data_i, cmd;
  logic [3:0] qspi_io_i, qspi_io_o, qspi_io_oe_o, fl_io;
  logic [2:0] pll_od_i, pll_output_divider_o;
  logic [11:0] pll_f_i, pll_f_o, pll_den_o;
  logic [5:0] pll_r_i, pll_r_o;
  logic [12:0] pll_num_o;
  logic [15:0] start_addr_o, ram_addr_o;
  logic [10:0] otp_addr_o;
  logic [7:0] ram_wdata_o;
  logic [7:0] ram [0:255];
  logic [31:0] otp_mem [0:63];
  int miscompares = 0;
  int cmp_count = 0;
  int we_cnt = 0;
  bil_loader dut_u (.*);
  bil_flash_mdl fl_u (.clk_i(mclk_i), .sclk_i(qspi_sclk_o), .cs_n_i(qspi_cs_n_o),
    .io0_i(qspi_io_o[0]), .io_o(fl_io), .cmd_o(cmd));
  assign qspi_io_i = (qspi_io_oe_o & qspi_io_o) | (~qspi_io_oe_o & fl_io);
  // OTP answers one cycle after the strobe, otherwise shows a moving pattern
  always @(posedge mclk_i) otp_data_i <= otp_rd_o ? otp_mem[otp_addr_o[5:0]] : ~otp_data_i;
  always @(posedge mclk_i) begin
    if (ram_we_o === 1'b1) begin
      ram[ram_addr_o[7:0]] <= ram_wdata_o;
      we_cnt <= we_cnt + 1;
    end
  end
  initial begin
    mclk_i = 0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] crc_f(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    foreach (b[i]) begin
      c = c ^ b[i];
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction
  // Mode 0 good check word, 1 skip value, 2 corrupted check word
  task automatic boot(input logic otp, input int s, input int mode);
    logic [7:0] img[$];
    logic [31:0] chk;
    int t;
    int n;
    for (n = 0; n < 4; n++) img.push_back(8'(s >> (8 * n)));
    repeat (4 * s) img.push_back(8'($urandom));
    chk = crc_f(img) ^ 32'(mode == 2);
    if (mode == 1) chk = 32'h0D15_AB1E;
    for (n = 0; n < 4; n++) img.push_back(chk[8 * n +: 8]);
    foreach (img[i]) begin
      fl_u.mem[i] = img[i];
      otp_mem[i / 4][8 * (i % 4) +: 8] = img[i];
    end
    security_i = otp ? 32'h0000_0020 : $urandom & 32'hFFFF_FFDF;
    dev_rst_n_i = 0;
    repeat (3) @(negedge mclk_i);
    we_cnt = 0;
    dev_rst_n_i = 1;
    t = 0;
    n = 0;
    while (boot_done_o !== 1'b1 && boot_err_o !== 1'b1 && n < 3000) begin
      @(negedge mclk_i);
      n++;
      if (t == 0 && (qspi_cs_n_o === 1'b0 || otp_rd_o === 1'b1)) t = n;
    end
    cmp("seq", 1, t >= 150 && t <= 1500);
    cmp("state", {mode != 2, mode != 2, mode == 2, otp}, {boot_done_o, core_run_o, boot_err_o, boot_otp_o});
    cmp("start", 0, start_addr_o);
    cmp("writes", 4 * s, we_cnt);
    for (n = 0; n < 4 * s; n++) cmp("ram", img[4 + n], ram[n]);
    if (!otp) cmp("cmd", 32'h6B00_0000, cmd);
  endtask
  initial begin
    repeat (40000) @(posedge mclk_i);
    miscompares++;
    test_done();
  end
  initial begin
    rst_i = 1;
    dev_rst_n_i = 0;
    pll_wr_i = 0;
    pll_od_i = 0;
    pll_f_i = 0;
    pll_r_i = 0;
    security_i = 0;
    otp_data_i = 0;
    void'($urandom(32'hd154));
    repeat (6) @(negedge mclk_i);
    rst_i = 0;
    @(negedge mclk_i);
    cmp("pd", 1, gpio_pd_en_o);
    cmp("pll", 21'h04_0FC0, {pll_output_divider_o, pll_f_o, pll_r_o});
    cmp("ratio", {13'h0040, 12'h004}, {pll_num_o, pll_den_o});
    dev_rst_n_i = 1;
    repeat (200) @(negedge mclk_i);
    dev_rst_n_i = 0;
    repeat (2) @(negedge mclk_i);
    cmp("abort", 2'b11, {qspi_cs_n_o, gpio_pd_en_o});
    boot(0, 3, 0);
    boot(0, 0, 1);
    boot(0, 2, 2);
    boot(1, 4, 0);
    boot(1, 0, 2);
    boot(1, 1, 1);
    repeat (4) boot(1'($urandom_range(0, 1)), $urandom_range(0, 8), $urandom_range(0, 2));
    repeat (4) begin
      pll_od_i = 3'($urandom);
      pll_f_i = 12'($urandom);
      pll_r_i = 6'($urandom);
      pll_wr_i = 1;
      @(negedge mclk_i);
      pll_wr_i = 0;
      repeat (2) @(negedge mclk_i);
      cmp("pll", {pll_od_i, pll_f_i, pll_r_i}, {pll_output_divider_o, pll_f_o, pll_r_o});
      cmp("ratio", {pll_f_i + 13'h1, 12'(2 * (pll_r_i + 1) * (pll_od_i + 1))}, {pll_num_o, pll_den_o});
    end
    test_done();
  end
endmodule
bind bil_loader bil_loader_chk #(.RAM_AW(RAM_AW)) chk_u (.*);
